/* File: verilog/serial_boot_id_gate_params.svh */
// Constants for the serial boot ID gate
`ifndef SERIAL_BOOT_ID_GATE_PARAMS_SVH
`define SERIAL_BOOT_ID_GATE_PARAMS_SVH
// Avalon-MM register byte addresses
`define REG_STATUS_ADDR 8'h00
`define REG_DECODE_ADDR 8'h04
`define REG_WDOPT_ADDR 8'h08
`define REG_RSTOPT_ADDR 8'h0c
`define REG_RXID_LO_ADDR 8'h10
`define REG_RXID_HI_ADDR 8'h14
`define REG_CTRL_ADDR 8'h18
// Flash addresses of stored bytes
`define FL_ADDR_OPT_MAIN 16'hffff
`define FL_ADDR_OPT_WD 16'hffdb
`define FL_ADDR_RVEC0 16'hfffc
`define FL_ADDR_RVEC1 16'hfffd
`define FL_ADDR_RVEC2 16'hfffe
`define FL_ADDR_ID1 16'hffdf
`define FL_ADDR_ID2 16'hffe3
`define FL_ADDR_ID3 16'hffeb
`define FL_ADDR_ID4 16'hffef
`define FL_ADDR_ID5 16'hfff3
`define FL_ADDR_ID6 16'hfff7
`define FL_ADDR_ID7 16'hfffb
// Reserved keys, first byte in low bits
`define KEY_ERASE 56'h45_53_41_52_65_4c_41
`define KEY_DISABLE 56'h74_63_65_74_6f_72_50
// Erased flash reads as all ones
`define OPT_ERASED 8'hff
// Watchdog initial counts
`define WD_CNT_0 16'h03ff
`define WD_CNT_1 16'h0fff
`define WD_CNT_2 16'h1fff
`define WD_CNT_3 16'h3fff
// Option bit positions
`define OPT_WDT_AUTO 0
`define OPT_ROM_GATE 2
`define OPT_ROM_SEL 3
`define OPT_VDET_LO 4
`define OPT_VMON 6
`define OPT_CSPRO 7
`define OPT_WD_CNT_LO 0
`define OPT_WD_WIN_LO 2
`endif

/* File: verilog/serial_boot_id_gate_pkg.sv */
// Types for the serial boot ID gate
package serial_boot_id_gate_pkg;
  typedef enum logic [1:0] {
    VDET_3V80,
    VDET_2V85,
    VDET_2V35,
    VDET_1V90
  } vdet_level_e;
  typedef enum logic [1:0] {
    WIN_25,
    WIN_50,
    WIN_75,
    WIN_100
  } refresh_window_e;
  typedef struct packed {
    logic watchdog_autostart;
    logic rom_protect;
    vdet_level_e vdet_level;
    logic voltage_monitor_reset_start;
    logic source_protect_at_reset;
    logic [15:0] wd_initial_count;
    refresh_window_e wd_refresh_window;
  } option_decode_s;
  typedef struct packed {
    logic unlocked;
    logic refused;
    logic erase_req;
    logic serial_disabled;
    logic parallel_block;
    logic check_done;
  } gate_status_s;
endpackage : serial_boot_id_gate_pkg

/* File: verilog/serial_boot_id_gate.sv */
// Serial boot ID gate: stored ID capture, key checks and option decode
// What this block does
// - Unless reset vector is all ones, compare seven received ID bytes before commands.
// - Full ID match lets subsequent programmer commands be acknowledged.
// - Any differing ID byte makes the gate refuse programmer commands.
// - Reset vector all ones skips the check and accepts all commands unless the serial-disable key is stored.
// - Stored ID bytes come from top bytes of seven fixed vectors.
// - Forced-erase key is 41 4C 65 52 41 53 45 across ID1..ID7.
// - Serial-disable key is 50 72 6F 74 65 63 74 across ID1..ID7.
// - A key counts only when all seven bytes match; partial is ordinary.
// - Erase key received and stored triggers full user ROM erase.
// - Erase key received, other stored ID except the serial-disable key: erase unless protect bits are 01b.
// - Erase key stored but not received: unless reset vector is all ones, mismatch, no commands, ROM kept.
// - Serial-disable key stored refuses all serial communication.
// - Serial-disable key plus ROM protect also blocks parallel access.
// - Main option bit 0 picks watchdog autostart; bit 1 reserved one.
// - ROM protection in force only when bit 2 is 1 and bit 3 is 0.
// - Option bits 5:4 pick voltage detection 0 threshold.
// - Option bit 6 low enables voltage monitor 0 reset after reset.
// - Option bit 7 low starts watchdog source protection mode.
// - Erased or blank option bytes read as all ones.
// - Second option bits 1:0 pick watchdog initial count.
// - Second option bits 3:2 pick refresh acknowledge window.
// - Main option at FFFF, second option at FFDB.
`timescale 1ns/100ps
`include "serial_boot_id_gate_params.svh"
module serial_boot_id_gate
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Flash read port used during the load sequence
  output logic [15:0] o_flash_addr,
  output logic o_flash_rd,
  input wire logic [7:0] i_flash_data,
  input wire logic i_flash_blank,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Decoded results
  output serial_boot_id_gate_pkg::option_decode_s o_option,
  output serial_boot_id_gate_pkg::gate_status_s o_status,
  output logic o_erase_pulse
);
  //------------------------------------------------------------
  // Load sequence
  //------------------------------------------------------------
  typedef enum logic [1:0] {
    LOAD,
    READY,
    CHECKED
  } state_e;
  localparam int N_LOAD = 12;
  state_e state_r, state_nxt;
  logic [3:0] idx_r;
  logic [7:0] opt_main_r;
  logic [7:0] opt_wd_r;
  logic [23:0] rvec_r;
  logic [55:0] stored_id_r;
  logic [55:0] rx_id_r;
  logic unlocked_r, refused_r, erase_r, erase_pulse_r, done_r;
  logic [15:0] load_addr;
  logic [7:0] load_byte;
  // Flash address for each load step
  assign load_addr =
    (idx_r == 4'd0) ? `FL_ADDR_OPT_MAIN :
    (idx_r == 4'd1) ? `FL_ADDR_OPT_WD :
    (idx_r == 4'd2) ? `FL_ADDR_RVEC0 :
    (idx_r == 4'd3) ? `FL_ADDR_RVEC1 :
    (idx_r == 4'd4) ? `FL_ADDR_RVEC2 :
    (idx_r == 4'd5) ? `FL_ADDR_ID1 :
    (idx_r == 4'd6) ? `FL_ADDR_ID2 :
    (idx_r == 4'd7) ? `FL_ADDR_ID3 :
    (idx_r == 4'd8) ? `FL_ADDR_ID4 :
    (idx_r == 4'd9) ? `FL_ADDR_ID5 :
    (idx_r == 4'd10) ? `FL_ADDR_ID6 : `FL_ADDR_ID7;
  // A blank part reads as erased flash
  assign load_byte = i_flash_blank ? `OPT_ERASED : i_flash_data;
  assign o_flash_addr = load_addr;
  assign o_flash_rd = (state_r == LOAD);
  //------------------------------------------------------------
  // Key and ID decisions
  //------------------------------------------------------------
  wire rx_is_erase = (rx_id_r == `KEY_ERASE);
  wire st_is_erase = (stored_id_r == `KEY_ERASE);
  wire st_is_disable = (stored_id_r == `KEY_DISABLE);
  wire id_match = (rx_id_r == stored_id_r);
  wire check_skip = (rvec_r == 24'hffffff);
  wire rom_protect = opt_main_r[`OPT_ROM_GATE] & ~opt_main_r[`OPT_ROM_SEL];
  // Erase when both keys, or received key with protect bits not 01b and no disable key stored
  wire do_erase = rx_is_erase & ~st_is_disable & (st_is_erase | ~rom_protect);
  // Stored erase key with other received ID falls to the normal compare
  wire grant = ~st_is_disable & (check_skip | id_match);
  //------------------------------------------------------------
  // Avalon-MM decode
  //------------------------------------------------------------
  wire acc = i_avs_read | i_avs_write;
  wire sel_status = (i_avs_address == `REG_STATUS_ADDR);
  wire sel_decode = (i_avs_address == `REG_DECODE_ADDR);
  wire sel_wdopt = (i_avs_address == `REG_WDOPT_ADDR);
  wire sel_rstopt = (i_avs_address == `REG_RSTOPT_ADDR);
  wire sel_rxlo = (i_avs_address == `REG_RXID_LO_ADDR);
  wire sel_rxhi = (i_avs_address == `REG_RXID_HI_ADDR);
  wire sel_ctrl = (i_avs_address == `REG_CTRL_ADDR);
  wire wr_ctrl = i_avs_write & sel_ctrl & i_avs_byteenable[0] & i_avs_writedata[0];
  logic [31:0] rd_mux;
  logic rd_valid_r;
  // Stall while loading, then one wait cycle for registered read data
  assign o_avs_waitrequest = acc & ((state_r == LOAD) | (i_avs_read & ~rd_valid_r));
  wire acc_done = acc & ~o_avs_waitrequest;
  always_comb
  begin
    if (sel_status)
      rd_mux = {26'h0, o_status};
    else if (sel_decode)
      rd_mux = {8'h0, o_option};
    else if (sel_wdopt)
      rd_mux = {24'h0, opt_wd_r};
    else if (sel_rstopt)
      rd_mux = {24'h0, opt_main_r};
    else if (sel_rxlo)
      rd_mux = rx_id_r[31:0];
    else if (sel_rxhi)
      rd_mux = {8'h0, rx_id_r[55:32]};
    else
      rd_mux = 32'h0;
  end
  //------------------------------------------------------------
  // Sequencer
  //------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      LOAD:
        if (idx_r == 4'(N_LOAD - 1))
          state_nxt = READY;
      READY:
        if (wr_ctrl & acc_done)
          state_nxt = CHECKED;
      CHECKED:
        if (wr_ctrl & acc_done)
          state_nxt = CHECKED;
      default:
        state_nxt = LOAD;
    endcase
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state_r <= LOAD;
      idx_r <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == LOAD)
        idx_r <= idx_r + 4'h1;
    end
  end
  // Captured once after reset and held until the next one
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      opt_main_r <= `OPT_ERASED;
      opt_wd_r <= `OPT_ERASED;
      rvec_r <= 24'h0;
      stored_id_r <= 56'h0;
    end
    else if (state_r == LOAD)
    begin
      if (idx_r == 4'd0)
        opt_main_r <= load_byte;
      else if (idx_r == 4'd1)
        opt_wd_r <= load_byte;
      else if (idx_r < 4'd5)
        rvec_r <= {load_byte, rvec_r[23:8]};
      else
        stored_id_r <= {load_byte, stored_id_r[55:8]};
    end
  end
  // Received ID registers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      rx_id_r <= 56'h0;
    else if (i_avs_write & acc_done)
    begin
      if (sel_rxlo)
        for (int b = 0; b < 4; b++)
          if (i_avs_byteenable[b])
            rx_id_r[b*8 +: 8] <= i_avs_writedata[b*8 +: 8];
      if (sel_rxhi)
        for (int b = 0; b < 3; b++)
          if (i_avs_byteenable[b])
            rx_id_r[32 + b*8 +: 8] <= i_avs_writedata[b*8 +: 8];
    end
  end
  // Check result on each check command
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      unlocked_r <= 1'b0;
      refused_r <= 1'b0;
      erase_r <= 1'b0;
      erase_pulse_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      erase_pulse_r <= 1'b0;
      if (wr_ctrl & acc_done & (state_r != LOAD))
      begin
        done_r <= 1'b1;
        erase_r <= do_erase;
        erase_pulse_r <= do_erase;
        unlocked_r <= grant & ~do_erase;
        refused_r <= ~grant & ~do_erase;
      end
    end
  end
  // Read data register
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      rd_valid_r <= 1'b0;
      o_avs_readdata <= 32'h0;
    end
    else
    begin
      rd_valid_r <= i_avs_read & ~rd_valid_r & (state_r != LOAD);
      o_avs_readdata <= rd_mux;
    end
  end
  //------------------------------------------------------------
  // Outputs and option decode
  //------------------------------------------------------------
  logic [15:0] wd_cnt;
  assign wd_cnt =
    (opt_wd_r[1:0] == 2'b00) ? `WD_CNT_0 :
    (opt_wd_r[1:0] == 2'b01) ? `WD_CNT_1 :
    (opt_wd_r[1:0] == 2'b10) ? `WD_CNT_2 : `WD_CNT_3;
  always_comb
  begin
    o_option.watchdog_autostart = ~opt_main_r[`OPT_WDT_AUTO];
    o_option.rom_protect = rom_protect;
    o_option.vdet_level =
      serial_boot_id_gate_pkg::vdet_level_e'(opt_main_r[`OPT_VDET_LO +: 2]);
    o_option.voltage_monitor_reset_start = ~opt_main_r[`OPT_VMON];
    o_option.source_protect_at_reset = ~opt_main_r[`OPT_CSPRO];
    o_option.wd_initial_count = wd_cnt;
    o_option.wd_refresh_window =
      serial_boot_id_gate_pkg::refresh_window_e'(opt_wd_r[`OPT_WD_WIN_LO +: 2]);
  end
  always_comb
  begin
    o_status.unlocked = unlocked_r;
    o_status.refused = refused_r;
    o_status.erase_req = erase_r;
    o_status.serial_disabled = st_is_disable & (state_r != LOAD);
    o_status.parallel_block = st_is_disable & rom_protect;
    o_status.check_done = done_r;
  end
  assign o_erase_pulse = erase_pulse_r;
  //------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------
  sequence s_check_cmd;
    wr_ctrl && acc_done && (state_r != LOAD);
  endsequence
  sequence s_load_first;
    (state_r == LOAD) && (idx_r == 4'd0);
  endsequence
  sequence s_load_id1;
    (state_r == LOAD) && (idx_r == 4'd5);
  endsequence
  a_match_unlocks: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_check_cmd and (id_match && !st_is_disable && !do_erase) |=> unlocked_r)
    else $error("matching ID did not unlock");
  a_mismatch_refuse: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_check_cmd and (!id_match && !check_skip && !do_erase) |=> refused_r && !unlocked_r)
    else $error("mismatching ID was not refused");
  a_skip_accepts: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_check_cmd and (check_skip && !st_is_disable && !do_erase) |=> unlocked_r)
    else $error("blank reset vector did not accept");
  a_disable_blocks: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    st_is_disable |-> !unlocked_r || $past(!st_is_disable))
    else $error("serial disabled yet unlocked");
  a_erase_pulse: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_check_cmd and (rx_is_erase && !st_is_erase && rom_protect) |=> !o_erase_pulse)
    else $error("erase despite protect");
  a_erase_both: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_check_cmd and (rx_is_erase && st_is_erase) |=> o_erase_pulse ##1 !o_erase_pulse)
    else $error("erase key pair did not erase once");
  a_options_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_r != LOAD |=> $stable(opt_main_r) && $stable(stored_id_r))
    else $error("captured values changed after load");
  a_load_length: assert property (@(posedge i_sys_clk)
    $fell(i_rst) |-> (state_r == LOAD) [*8] ##1 (state_r == LOAD) [*4] ##1 (state_r == READY))
    else $error("load sequence length wrong");
  //------------------------------------------------------------
  // Assertions on keys, load and bus
  //------------------------------------------------------------
  a_disable_no_erase: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_check_cmd and st_is_disable |=> refused_r && !o_erase_pulse)
    else $error("serial disabled yet answered");
  a_stored_erase_only: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_check_cmd and (st_is_erase && !rx_is_erase && !check_skip) |=> refused_r && !o_erase_pulse)
    else $error("stored erase key without match was accepted");
  a_erase_unprot: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_check_cmd and (rx_is_erase && !st_is_disable && !rom_protect) |=> o_erase_pulse)
    else $error("unprotected erase key did not erase");
  a_erase_exclusive: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_erase_pulse |-> erase_r && !unlocked_r && !refused_r)
    else $error("erase left a grant or refusal");
  a_load_stall: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (state_r == LOAD) && acc |-> o_avs_waitrequest)
    else $error("bus answered during load");
  a_blank_erased: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_load_first and i_flash_blank |=> opt_main_r == `OPT_ERASED)
    else $error("blank part option not all ones");
  a_main_addr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_load_first |-> o_flash_addr == `FL_ADDR_OPT_MAIN)
    else $error("main option fetched from wrong address");
  a_id_first: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_load_id1 |-> o_flash_addr == `FL_ADDR_ID1)
    else $error("first stored ID byte from wrong address");
  a_check_done: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_check_cmd |=> done_r)
    else $error("check command did not complete");
  a_partial_key: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_check_cmd and (!rx_is_erase && !id_match && !check_skip) |=> refused_r && !o_erase_pulse)
    else $error("partial key was not an ordinary mismatch");
endmodule : serial_boot_id_gate

/* File: verif/id_gate_flash_model.sv */
// Flash array model serving the option, reset vector and stored ID bytes
`timescale 1ns/100ps
`include "serial_boot_id_gate_params.svh"
module id_gate_flash_model
(
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_opt_main,
  input wire logic [7:0] i_opt_wd,
  input wire logic [23:0] i_rvec,
  input wire logic [55:0] i_id,
  output logic [7:0] o_data
);
  // Unused addresses return a pattern that tracks the address, never stale data
  always_comb
  begin
    case (i_addr)
      `FL_ADDR_OPT_MAIN: o_data = i_opt_main;
      `FL_ADDR_OPT_WD: o_data = i_opt_wd;
      `FL_ADDR_RVEC0: o_data = i_rvec[7:0];
      `FL_ADDR_RVEC1: o_data = i_rvec[15:8];
      `FL_ADDR_RVEC2: o_data = i_rvec[23:16];
      `FL_ADDR_ID1: o_data = i_id[7:0];
      `FL_ADDR_ID2: o_data = i_id[15:8];
      `FL_ADDR_ID3: o_data = i_id[23:16];
      `FL_ADDR_ID4: o_data = i_id[31:24];
      `FL_ADDR_ID5: o_data = i_id[39:32];
      `FL_ADDR_ID6: o_data = i_id[47:40];
      `FL_ADDR_ID7: o_data = i_id[55:48];
      default: o_data = ~i_addr[7:0];
    endcase
  end
endmodule : id_gate_flash_model

/* File: verif/tb_serial_boot_id_gate.sv */
// Self-checking testbench for the serial boot ID gate
`timescale 1ns/100ps
`include "serial_boot_id_gate_params.svh"
module tb_serial_boot_id_gate;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [15:0] fl_addr;
  logic fl_rd;
  logic [7:0] fl_data;
  logic fl_blank = 1'b0;
  logic [7:0] av_addr = 8'h00;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic [31:0] av_rdata;
  logic av_wait;
  serial_boot_id_gate_pkg::option_decode_s opt;
  serial_boot_id_gate_pkg::gate_status_s stat;
  logic erase_pulse;
  logic [7:0] opt_main = 8'hff;
  logic [7:0] opt_wd = 8'hff;
  logic [23:0] rvec = 24'hffffff;
  logic [55:0] id_st = 56'h0;
  logic [7:0] e_main;
  logic [7:0] e_wd;
  logic [23:0] e_rvec;
  logic [55:0] e_id;
  int n_errors = 0;
  int checked = 0;

  always #20 i_sys_clk = ~i_sys_clk;

  serial_boot_id_gate dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .o_flash_addr(fl_addr),
    .o_flash_rd(fl_rd), .i_flash_data(fl_data), .i_flash_blank(fl_blank),
    .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
    .i_avs_writedata(av_wdata), .i_avs_byteenable(4'hf), .o_avs_readdata(av_rdata),
    .o_avs_waitrequest(av_wait), .o_option(opt), .o_status(stat), .o_erase_pulse(erase_pulse));

  id_gate_flash_model flash_u (.i_addr(fl_addr), .i_opt_main(opt_main), .i_opt_wd(opt_wd),
    .i_rvec(rvec), .i_id(id_st), .o_data(fl_data));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask : check

  task automatic close_out();
    if (n_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    av_addr <= a;
    av_rd <= rd;
    av_wr <= ~rd;
    av_wdata <= wd;
    @(posedge i_sys_clk);
    while (av_wait !== 1'b0 && n < 100)
    begin
      n++;
      @(posedge i_sys_clk);
    end
    if (n == 100)
      check(32'h1, 32'h0);
    rdat = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask : bus

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  function automatic logic [23:0] exp_option();
    logic [15:0] cnt;
    case (e_wd[1:0])
      2'h0: cnt = 16'h03ff;
      2'h1: cnt = 16'h0fff;
      2'h2: cnt = 16'h1fff;
      default: cnt = 16'h3fff;
    endcase
    return {~e_main[0], e_main[2] & ~e_main[3], e_main[5:4], ~e_main[6], ~e_main[7],
            cnt, e_wd[3:2]};
  endfunction : exp_option

  function automatic logic [5:0] exp_status(input logic [55:0] rx);
    logic prot, dis, er, ok;
    prot = e_main[2] & ~e_main[3];
    dis = (e_id == `KEY_DISABLE);
    er = !dis && rx == `KEY_ERASE && (e_id == `KEY_ERASE || !prot);
    ok = !dis && !er && (e_rvec == 24'hffffff || rx == e_id);
    return {ok, !er && !ok, er, dis, dis && prot, 1'b1};
  endfunction : exp_status

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [31:0] rd;
    logic [63:0] r64;
    logic [55:0] rx;
    int ks, kr, pulses;
    logic [5:0] es;
    rd = $urandom(32'hbbf4);
    for (int i = 0; i < 40; i++)
    begin
      ks = i % 4;
      kr = (i / 4) % 4;
      r64 = {$urandom(), $urandom()};
      @(posedge i_sys_clk);
      i_rst <= 1'b1;
      opt_main <= 8'($urandom()) | 8'h02;
      opt_wd <= 8'($urandom()) | 8'hf0;
      id_st <= (ks == 1) ? `KEY_ERASE : (ks == 2) ? `KEY_DISABLE : r64[55:0];
      rvec <= (ks != 1 && ks != 2 && kr < 2 && i % 3 == 0) ? 24'hffffff : r64[23:0] & 24'hfffffe;
      fl_blank <= (i % 8 == 7 && kr < 2);
      repeat (6) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      e_main = fl_blank ? 8'hff : opt_main;
      e_wd = fl_blank ? 8'hff : opt_wd;
      e_rvec = fl_blank ? 24'hffffff : rvec;
      e_id = fl_blank ? {56{1'b1}} : id_st;
      rx = (kr == 0) ? r64[63:8] : (kr == 1) ? e_id : `KEY_ERASE;
      if (kr == 3)
        rx = rx ^ (56'hff << (8 * ($urandom() % 7)));
      @(posedge i_sys_clk);
      check({31'h0, fl_rd}, 32'h1);
      bus(1'b1, `REG_STATUS_ADDR, 32'h0, rd);
      check({31'h0, fl_rd}, 32'h0);
      // Flash changes after the load must not reach the decoded values
      opt_main <= ~opt_main;
      opt_wd <= ~opt_wd;
      rvec <= ~rvec;
      id_st <= ~id_st;
      fl_blank <= ~fl_blank;
      bus(1'b1, `REG_DECODE_ADDR, 32'h0, rd);
      check(rd, {8'h00, exp_option()});
      check({8'h00, opt}, {8'h00, exp_option()});
      bus(1'b1, `REG_WDOPT_ADDR, 32'h0, rd);
      check(rd, {24'h0, e_wd});
      bus(1'b1, `REG_RSTOPT_ADDR, 32'h0, rd);
      check(rd, {24'h0, e_main});
      bus(1'b1, 8'h1c, 32'h0, rd);
      check(rd, 32'h0);
      bus(1'b0, `REG_RXID_LO_ADDR, rx[31:0], rd);
      bus(1'b0, `REG_RXID_HI_ADDR, {8'h00, rx[55:32]}, rd);
      bus(1'b0, `REG_CTRL_ADDR, 32'h1, rd);
      pulses = 0;
      for (int c = 0; c < 4; c++)
      begin
        @(negedge i_sys_clk);
        if (erase_pulse === 1'b1)
          pulses++;
        if (c == 2)
          check({26'h0, stat}, {26'h0, exp_status(rx)});
      end
      es = exp_status(rx);
      check(32'(pulses), {31'h0, es[3]});
      bus(1'b1, `REG_STATUS_ADDR, 32'h0, rd);
      check(rd, {26'h0, exp_status(rx)});
    end
    close_out();
  end

  initial
  begin
    #800000;
    n_errors++;
    close_out();
  end
endmodule : tb_serial_boot_id_gate
